// *** src/oag_decoder.sv ***
// operand address generator: decodes mode, fetches extension bytes and forms the address
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE_01 - inherent: one byte, no operand fetch
// RULE_02 - immediate: next byte is operand value
// RULE_03 - short direct: one address byte, page zero
// RULE_04 - long direct: two address bytes, full space
// RULE_05 - indexed: index plus offset, unsigned
// RULE_06 - no offset indexed: index alone, no bytes
// RULE_07 - short indexed: byte offset, up to 1fe
// RULE_08 - long indexed: word offset, full space
// RULE_09 - indirect: pointer address follows opcode
// RULE_10 - short indirect: byte pointer, page zero
// RULE_11 - long indirect: word pointer from page zero
// RULE_12 - indirect indexed: pointer plus index register
// RULE_13 - short indirect indexed: byte pointer, up to 1fe
// RULE_14 - short forms page zero, long forms full
// RULE_15 - read modify write only short forms
// RULE_16 - mask set op sets level 3
// RULE_17 - mask clear op sets level 0
// RULE_18 - relative: pc plus signed 8-bit displacement
// RULE_19 - prefix 90 selects second index register
// RULE_20 - prefix 92 turns direct/indexed into indirect
// RULE_21 - prefix 91 second index indirect indexed
// RULE_22 - words msb first, sums carry, no wrap
// RULE_23 - extension bytes in order, pc advances past
module oag_decoder #(
   parameter int unsigned ADDR_W = oag_pkg::ADDR_W
) (
   input  wire logic                    clk_i,
   input  wire logic                    arst_n_i,
   // instruction start: opcode already classified by the core's opcode table
   input  wire logic                    start_i,
   input  wire logic [7:0]              prefix_i,
   input  wire logic                    prefix_valid_i,
   input  wire oag_pkg::oag_mode_e      mode_i,
   input  wire oag_pkg::oag_inh_e       inh_op_i,
   input  wire logic                    rmw_i,
   input  wire logic [ADDR_W-1:0]       pc_i,
   input  wire logic [7:0]              idx_first_i,
   input  wire logic [7:0]              idx_second_i,
   // memory byte channel
   input  wire logic                    mem_valid_i,
   input  wire logic [7:0]              mem_data_i,
   output logic                         mem_req_o,
   output logic [ADDR_W-1:0]            mem_addr_o,
   // results
   output logic                         busy_o,
   output logic                         done_o,
   output logic [ADDR_W-1:0]            ea_o,
   output logic [7:0]                   operand_o,
   output logic                         operand_imm_o,
   output logic [ADDR_W-1:0]            next_pc_o,
   output logic [1:0]                   mask_level_o,
   output logic                         illegal_o
);
   typedef enum logic [2:0] {
      S_IDLE,
      S_EXT,
      S_PTR,
      S_DISP,
      S_DONE
   } oag_state_e;

   oag_state_e          state_q;
   oag_pkg::oag_mode_e  mode_q;
   logic                second_q;
   logic [2:0]          ext_left_q;
   logic                ext_first_q;
   logic [2:0]          ptr_left_q;
   logic                ptr_first_q;
   logic [ADDR_W-1:0]   fetch_pc_q;
   logic [ADDR_W-1:0]   ptr_addr_q;
   logic [7:0]          index_q;
   logic [ADDR_W-1:0]   ea_q;
   logic [7:0]          operand_q;
   logic                operand_imm_q;
   logic [ADDR_W-1:0]   next_pc_q;
   logic [1:0]          mask_q;
   logic                illegal_q;
   logic                done_q;

   oag_pkg::oag_mode_e  eff_mode_d;
   logic                second_d;
   logic [2:0]          ext_bytes_d;
   logic [2:0]          ptr_bytes_d;
   logic                rmw_bad_d;

   oag_fetch_if f ();

   oag_word_asm u_asm (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .f        (f)
   );

   // prefix rewrites the opcode's mode and index choice
   always_comb begin
      eff_mode_d = mode_i;
      second_d   = 1'b0;
      if (prefix_valid_i && prefix_i == oag_pkg::PFX_SECOND_INDEX) begin
         second_d = 1'b1; // see RULE_19
      end else if (prefix_valid_i && prefix_i == oag_pkg::PFX_INDIRECT) begin
         unique case (mode_i) // see RULE_20
            oag_pkg::OAG_DIR_SHORT: eff_mode_d = oag_pkg::OAG_IND_SHORT;
            oag_pkg::OAG_DIR_LONG:  eff_mode_d = oag_pkg::OAG_IND_LONG;
            oag_pkg::OAG_IDX_SHORT: eff_mode_d = oag_pkg::OAG_INDIDX_SHORT;
            oag_pkg::OAG_IDX_LONG:  eff_mode_d = oag_pkg::OAG_INDIDX_LONG;
            default:                eff_mode_d = mode_i;
         endcase
      end else if (prefix_valid_i && prefix_i == oag_pkg::PFX_INDIRECT_SECOND) begin
         second_d = 1'b1; // see RULE_21
         unique case (mode_i)
            oag_pkg::OAG_IDX_SHORT: eff_mode_d = oag_pkg::OAG_INDIDX_SHORT;
            oag_pkg::OAG_IDX_LONG:  eff_mode_d = oag_pkg::OAG_INDIDX_LONG;
            default:                eff_mode_d = mode_i;
         endcase
      end
   end

   // bytes after the opcode and pointer size per mode
   always_comb begin
      ext_bytes_d = oag_pkg::BYTES_NONE;
      ptr_bytes_d = oag_pkg::BYTES_NONE;
      unique case (eff_mode_d)
         oag_pkg::OAG_INHERENT:     ext_bytes_d = oag_pkg::BYTES_NONE; // see RULE_01
         oag_pkg::OAG_IMMEDIATE:    ext_bytes_d = oag_pkg::BYTES_ONE;  // see RULE_02
         oag_pkg::OAG_DIR_SHORT:    ext_bytes_d = oag_pkg::BYTES_ONE;  // see RULE_03
         oag_pkg::OAG_DIR_LONG:     ext_bytes_d = oag_pkg::BYTES_TWO;  // see RULE_04
         oag_pkg::OAG_IDX_NONE:     ext_bytes_d = oag_pkg::BYTES_NONE; // see RULE_06
         oag_pkg::OAG_IDX_SHORT:    ext_bytes_d = oag_pkg::BYTES_ONE;  // see RULE_07
         oag_pkg::OAG_IDX_LONG:     ext_bytes_d = oag_pkg::BYTES_TWO;  // see RULE_08
         oag_pkg::OAG_RELATIVE:     ext_bytes_d = oag_pkg::BYTES_ONE;  // see RULE_18
         oag_pkg::OAG_IND_SHORT, oag_pkg::OAG_INDIDX_SHORT: begin
            ext_bytes_d = oag_pkg::BYTES_ONE;  // see RULE_10
            ptr_bytes_d = oag_pkg::BYTES_ONE;  // see RULE_13
         end
         oag_pkg::OAG_IND_LONG, oag_pkg::OAG_INDIDX_LONG: begin
            ext_bytes_d = oag_pkg::BYTES_ONE;  // see RULE_11
            ptr_bytes_d = oag_pkg::BYTES_TWO;
         end
         default: ext_bytes_d = oag_pkg::BYTES_NONE;
      endcase
   end

   // read-modify-write only allows page-zero forms (see RULE_15)
   always_comb begin
      unique case (eff_mode_d)
         oag_pkg::OAG_DIR_LONG, oag_pkg::OAG_IDX_LONG,
         oag_pkg::OAG_IND_LONG, oag_pkg::OAG_INDIDX_LONG: rmw_bad_d = rmw_i;
         default:                                          rmw_bad_d = 1'b0;
      endcase
   end

   // byte channel into the assembler
   assign f.take  = mem_req_o && mem_valid_i;
   assign f.first = (state_q == S_EXT) ? ext_first_q : ptr_first_q;
   assign f.data  = mem_data_i;

   assign mem_req_o  = (state_q == S_EXT) || (state_q == S_PTR);
   assign mem_addr_o = (state_q == S_PTR) ? ptr_addr_q : fetch_pc_q;

   // sequencer: opcode, then extension bytes in order, then pointer bytes
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q     <= S_IDLE;
         mode_q      <= oag_pkg::OAG_INHERENT;
         second_q    <= 1'b0;
         ext_left_q  <= oag_pkg::BYTES_NONE;
         ext_first_q <= 1'b1;
         ptr_left_q  <= oag_pkg::BYTES_NONE;
         ptr_first_q <= 1'b1;
         fetch_pc_q  <= '0;
         ptr_addr_q  <= '0;
         index_q     <= 8'h00;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               if (start_i) begin
                  mode_q      <= eff_mode_d;
                  second_q    <= second_d;
                  index_q     <= second_d ? idx_second_i : idx_first_i;
                  ext_left_q  <= ext_bytes_d;
                  ptr_left_q  <= ptr_bytes_d;
                  ext_first_q <= 1'b1;
                  ptr_first_q <= 1'b1;
                  fetch_pc_q  <= ADDR_W'(pc_i + 1'b1); // see RULE_23
                  state_q     <= (ext_bytes_d == oag_pkg::BYTES_NONE) ? S_DISP : S_EXT;
               end
            end
            S_EXT: begin
               if (mem_valid_i) begin
                  fetch_pc_q  <= ADDR_W'(fetch_pc_q + 1'b1); // see RULE_23
                  ext_first_q <= 1'b0;
                  ext_left_q  <= ext_left_q - 3'h1;
                  if (ext_left_q == oag_pkg::BYTES_ONE) begin
                     // pointer lives in page zero at the fetched byte (see RULE_09)
                     ptr_addr_q <= {oag_pkg::PAGE_ZERO_HI, mem_data_i};
                     state_q    <= (ptr_left_q == oag_pkg::BYTES_NONE) ? S_DISP : S_PTR;
                  end
               end
            end
            S_PTR: begin
               if (mem_valid_i) begin
                  // word pointer from consecutive locations (see RULE_22)
                  ptr_addr_q  <= ADDR_W'(ptr_addr_q + 1'b1);
                  ptr_first_q <= 1'b0;
                  ptr_left_q  <= ptr_left_q - 3'h1;
                  if (ptr_left_q == oag_pkg::BYTES_ONE) begin
                     state_q <= S_DISP;
                  end
               end
            end
            S_DISP:  state_q <= S_DONE;
            S_DONE:  state_q <= S_IDLE;
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // effective address: unsigned sums carry upward, never wrap within the byte
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ea_q          <= '0;
         operand_q     <= 8'h00;
         operand_imm_q <= 1'b0;
         next_pc_q     <= '0;
      end else if (state_q == S_DISP) begin
         next_pc_q     <= fetch_pc_q; // see RULE_23
         operand_imm_q <= (mode_q == oag_pkg::OAG_IMMEDIATE);
         operand_q     <= f.word[7:0]; // see RULE_02
         unique case (mode_q)
            oag_pkg::OAG_INHERENT:     ea_q <= '0; // see RULE_01
            oag_pkg::OAG_IMMEDIATE:    ea_q <= '0;
            oag_pkg::OAG_DIR_SHORT:    ea_q <= ADDR_W'(f.word[7:0]); // see RULE_03
            oag_pkg::OAG_DIR_LONG:     ea_q <= ADDR_W'(f.word); // see RULE_04
            oag_pkg::OAG_IDX_NONE:     ea_q <= ADDR_W'(index_q); // see RULE_06
            oag_pkg::OAG_IDX_SHORT:    ea_q <= ADDR_W'(f.word[7:0]) + ADDR_W'(index_q); // see RULE_07
            oag_pkg::OAG_IDX_LONG:     ea_q <= ADDR_W'(f.word) + ADDR_W'(index_q); // see RULE_05
            oag_pkg::OAG_IND_SHORT:    ea_q <= ADDR_W'(f.word[7:0]); // see RULE_10
            oag_pkg::OAG_IND_LONG:     ea_q <= ADDR_W'(f.word); // see RULE_11
            oag_pkg::OAG_INDIDX_SHORT: ea_q <= ADDR_W'(f.word[7:0]) + ADDR_W'(index_q); // see RULE_13
            oag_pkg::OAG_INDIDX_LONG:  ea_q <= ADDR_W'(f.word) + ADDR_W'(index_q); // see RULE_12
            // displacement counts from the end of the instruction
            oag_pkg::OAG_RELATIVE:
               ea_q <= ADDR_W'(fetch_pc_q + {{(ADDR_W-8){f.word[7]}}, f.word[7:0]}); // see RULE_18
            default:                   ea_q <= '0;
         endcase
      end
   end

   // interrupt mask level, changed only by the two inherent mask ops
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mask_q <= oag_pkg::MASK_LEVEL_NONE;
      end else if (state_q == S_IDLE && start_i && eff_mode_d == oag_pkg::OAG_INHERENT) begin
         if (inh_op_i == oag_pkg::OAG_INH_MASK_SET) begin
            mask_q <= oag_pkg::MASK_LEVEL_NONE; // see RULE_16
         end else if (inh_op_i == oag_pkg::OAG_INH_MASK_CLEAR) begin
            mask_q <= oag_pkg::MASK_LEVEL_ALL; // see RULE_17
         end
      end
   end

   // completion and illegal long-form read-modify-write flag
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         illegal_q <= 1'b0;
         done_q    <= 1'b0;
      end else begin
         done_q <= (state_q == S_DISP);
         if (state_q == S_IDLE && start_i) begin
            illegal_q <= rmw_bad_d; // see RULE_15
         end
      end
   end

   assign busy_o        = (state_q != S_IDLE);
   assign done_o        = done_q;
   assign ea_o          = ea_q;
   assign operand_o     = operand_q;
   assign operand_imm_o = operand_imm_q;
   assign next_pc_o     = next_pc_q;
   assign mask_level_o  = mask_q;
   assign illegal_o     = illegal_q;

   chk_short_page_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE_14
      done_o && (mode_q == oag_pkg::OAG_DIR_SHORT || mode_q == oag_pkg::OAG_IND_SHORT)
      |-> ea_o[ADDR_W-1:8] == 8'h00)
      else $error("short form left page zero");
   chk_mask_set_level: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE_16
      state_q == S_IDLE && start_i && eff_mode_d == oag_pkg::OAG_INHERENT
      && inh_op_i == oag_pkg::OAG_INH_MASK_SET |=> mask_level_o == 2'h3)
      else $error("mask set did not reach level 3");
   chk_mask_clear_level: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE_17
      state_q == S_IDLE && start_i && eff_mode_d == oag_pkg::OAG_INHERENT
      && inh_op_i == oag_pkg::OAG_INH_MASK_CLEAR |=> mask_level_o == 2'h0)
      else $error("mask clear did not reach level 0");
   chk_inherent_no_fetch: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE_01
      state_q == S_IDLE && start_i && eff_mode_d == oag_pkg::OAG_INHERENT
      |=> !mem_req_o ##1 done_o)
      else $error("inherent op fetched a byte");
   chk_short_idx_range: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE_07
      done_o && mode_q == oag_pkg::OAG_IDX_SHORT |-> ea_o <= 16'h01fe)
      else $error("short indexed address out of range");
   chk_pc_past_ext: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE_23
      state_q == S_IDLE && start_i && ext_bytes_d == oag_pkg::BYTES_NONE
      |=> ##1 next_pc_o == ADDR_W'($past(pc_i, 2) + 1'b1))
      else $error("pc not advanced past opcode");
   chk_ptr_page_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE_09
      $rose(state_q == S_PTR) |-> ptr_addr_q[ADDR_W-1:8] == 8'h00)
      else $error("pointer not in page zero");
   chk_rmw_long_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see RULE_15
      state_q == S_IDLE && start_i && rmw_i && eff_mode_d == oag_pkg::OAG_DIR_LONG
      |=> illegal_o)
      else $error("long rmw not flagged");
endmodule
`default_nettype wire

// *** include/oag_pkg.sv ***
// package: addressing modes, prefixes and widths for the operand address generator
package oag_pkg;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;
   localparam logic [7:0] PFX_SECOND_INDEX   = 8'h90;
   localparam logic [7:0] PFX_INDIRECT       = 8'h92;
   localparam logic [7:0] PFX_INDIRECT_SECOND = 8'h91;
   localparam logic [1:0] MASK_LEVEL_ALL  = 2'h0;
   localparam logic [1:0] MASK_LEVEL_NONE = 2'h3;
   localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
   localparam logic [2:0] BYTES_NONE = 3'h0;
   localparam logic [2:0] BYTES_ONE  = 3'h1;
   localparam logic [2:0] BYTES_TWO  = 3'h2;

   typedef enum logic [3:0] {
      OAG_INHERENT,
      OAG_IMMEDIATE,
      OAG_DIR_SHORT,
      OAG_DIR_LONG,
      OAG_IDX_NONE,
      OAG_IDX_SHORT,
      OAG_IDX_LONG,
      OAG_IND_SHORT,
      OAG_IND_LONG,
      OAG_INDIDX_SHORT,
      OAG_INDIDX_LONG,
      OAG_RELATIVE
   } oag_mode_e;

   typedef enum logic [1:0] {
      OAG_INH_OTHER,
      OAG_INH_MASK_SET,
      OAG_INH_MASK_CLEAR
   } oag_inh_e;
endpackage

// *** include/oag_fetch_if.sv ***
// interface: byte fetch channel between sequencer and byte assembler
`timescale 1ns/1ps
`default_nettype none
interface oag_fetch_if;
   logic       take;
   logic       first;
   logic [7:0] data;
   logic [15:0] word;
   modport seq (output take, output first, output data, input word);
   modport asm (input take, input first, input data, output word);
endinterface
`default_nettype wire

// *** src/oag_word_asm.sv ***
// byte assembler: builds a word from bytes fetched msb first
`timescale 1ns/1ps
`default_nettype none
module oag_word_asm (
   input  wire logic  clk_i,
   input  wire logic  arst_n_i,
   oag_fetch_if.asm   f
);
   logic [15:0] word_q;

   // first byte lands as low byte, a second shifts it up: msb first (see RULE_22)
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         word_q <= 16'h0000;
      end else if (f.take) begin
         word_q <= f.first ? {8'h00, f.data} : {word_q[7:0], f.data};
      end
   end

   assign f.word = word_q;
endmodule
`default_nettype wire

// *** verification/oag_mem_model.sv ***
// memory partner: answers byte fetches with an address-derived pattern after a chosen wait
`timescale 1ns/1ps
`default_nettype none
module oag_mem_model (
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        req_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [1:0]  wait_i,
   input  wire logic [7:0]  key_i,
   output logic             valid_o,
   output logic [7:0]       data_o
);
   logic [1:0] cnt_q;
   logic [7:0] last_q;

   // a wait of up to three cycles models a slow memory; zero gives the same-cycle answer
   assign valid_o = req_i && (cnt_q == wait_i);
   // data lines have no pull: outside an answer they show the inverse of the last byte
   assign data_o  = valid_o ? (addr_i[7:0] ^ addr_i[15:8] ^ key_i) : ~last_q;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i)
         cnt_q <= 2'h0;
      else if (!req_i || valid_o)
         cnt_q <= 2'h0;
      else
         cnt_q <= cnt_q + 2'h1;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i)
         last_q <= 8'h00;
      else if (valid_o)
         last_q <= data_o;
   end
endmodule
`default_nettype wire

// *** verification/cpu_operand_address_generator_test.sv ***
// self-checking bench for the operand address generator
`timescale 1ns/1ps
`default_nettype none
`define OAG_CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin miscompares++; $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module cpu_operand_address_generator_test;
   typedef struct {
      logic [15:0] ea;
      logic [15:0] npc;
      logic [7:0]  opd;
      logic [1:0]  mask;
      bit          chk_ea;
      bit          chk_npc;
      bit          chk_opd;
      bit          chk_ill;
      int          nb;
   } oag_exp_s;

   logic               clk_i, arst_n_i, start_i, prefix_valid_i, rmw_i, mem_valid_i, mem_req_o;
   logic               busy_o, done_o, operand_imm_o, illegal_o;
   logic [7:0]         prefix_i, idx_first_i, idx_second_i, mem_data_i, operand_o, key;
   logic [15:0]        pc_i, mem_addr_o, ea_o, next_pc_o;
   logic [1:0]         mask_level_o, wt, mask_exp;
   logic [31:0]        rnd_a, rnd_b;
   oag_pkg::oag_mode_e mode_i;
   oag_pkg::oag_inh_e  inh_op_i;
   oag_exp_s           exp_q[$];
   oag_exp_s           e_mon;
   int                 miscompares = 0, tests_run = 0, taken = 0, seed = 31876, i, r;
   // modes by enum position, with prefix; entry 20 carries a prefix that is not qualified
   logic [3:0] tm [21] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h3, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6,
                           4'h6, 4'h2, 4'h3, 4'h5, 4'h6, 4'h5, 4'h6, 4'hb, 4'h2, 4'h5};
   logic [7:0] tp [21] = '{8'h00, 8'h90, 8'h00, 8'h90, 8'h00, 8'h00, 8'h00, 8'h90, 8'h00, 8'h90, 8'h00,
                           8'h90, 8'h92, 8'h92, 8'h92, 8'h92, 8'h91, 8'h91, 8'h00, 8'h55, 8'h90};

   oag_decoder i_oag_decoder (.clk_i(clk_i), .arst_n_i(arst_n_i), .start_i(start_i), .prefix_i(prefix_i),
      .prefix_valid_i(prefix_valid_i), .mode_i(mode_i), .inh_op_i(inh_op_i), .rmw_i(rmw_i), .pc_i(pc_i),
      .idx_first_i(idx_first_i), .idx_second_i(idx_second_i), .mem_valid_i(mem_valid_i),
      .mem_data_i(mem_data_i), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .busy_o(busy_o),
      .done_o(done_o), .ea_o(ea_o), .operand_o(operand_o), .operand_imm_o(operand_imm_o),
      .next_pc_o(next_pc_o), .mask_level_o(mask_level_o), .illegal_o(illegal_o));

   oag_mem_model i_oag_mem_model (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(mem_req_o), .addr_i(mem_addr_o),
      .wait_i(wt), .key_i(key), .valid_o(mem_valid_i), .data_o(mem_data_i));

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   function automatic logic [7:0] mb(input logic [15:0] a, input logic [7:0] k);
      return a[7:0] ^ a[15:8] ^ k;
   endfunction

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic run(input logic [3:0] m, input logic [7:0] pfx, input logic pv, input oag_pkg::oag_inh_e inh,
                      input logic rmw, input logic dup, input logic [15:0] p, input logic [7:0] x1,
                      input logic [7:0] x2, input logic [7:0] k, input logic [1:0] w8);
      oag_exp_s    e;
      logic [3:0]  mm;
      logic [7:0]  x, a;
      logic [15:0] w, pz, pw;
      bit          got;
      mm = m;
      x = pv && (pfx == oag_pkg::PFX_SECOND_INDEX || pfx == oag_pkg::PFX_INDIRECT_SECOND) ? x2 : x1;
      if (pv && (pfx == oag_pkg::PFX_INDIRECT || pfx == oag_pkg::PFX_INDIRECT_SECOND) && m inside {2, 3, 5, 6})
         mm = (m == 4'h2) ? 4'h7 : (m == 4'h3) ? 4'h8 : m + 4'h4;
      a = mb(p + 16'h1, k);
      w = {a, mb(p + 16'h2, k)};
      pz = {oag_pkg::PAGE_ZERO_HI, a};
      // the pointer word may straddle 00ff/0100: the sum carries, it does not wrap
      pw = {mb(pz, k), mb(pz + 16'h1, k)};
      e.npc = p + 16'h2;
      e.opd = a;
      e.chk_ea = 1'b1;
      e.chk_npc = 1'b1;
      e.chk_opd = 1'b0;
      e.chk_ill = 1'b0;
      case (mm)
         4'h0: begin e.nb = 0; e.npc = p + 16'h1; e.chk_ea = 1'b0; end
         4'h1: begin e.nb = 1; e.chk_ea = 1'b0; e.chk_opd = 1'b1; end
         4'h2: begin e.nb = 1; e.ea = {8'h00, a}; end
         4'h3: begin e.nb = 2; e.ea = w; e.npc = p + 16'h3; end
         4'h4: begin e.nb = 0; e.ea = {8'h00, x}; e.npc = p + 16'h1; end
         4'h5: begin e.nb = 1; e.ea = {8'h00, a} + {8'h00, x}; end
         4'h6: begin e.nb = 2; e.ea = w + {8'h00, x}; e.npc = p + 16'h3; end
         4'h7: begin e.nb = 2; e.ea = {8'h00, mb(pz, k)}; end
         4'h8: begin e.nb = 3; e.ea = pw; end
         4'h9: begin e.nb = 2; e.ea = {8'h00, mb(pz, k)} + {8'h00, x}; end
         4'ha: begin e.nb = 3; e.ea = pw + {8'h00, x}; end
         default: begin e.nb = 1; e.ea = p + 16'h2 + {{8{a[7]}}, a}; end
      endcase
      if (rmw && (m == 4'h3 || m == 4'h6)) begin
         e.chk_ill = 1'b1;
         e.chk_ea = 1'b0;
         e.chk_npc = 1'b0;
      end
      if (m == 4'h0 && inh == oag_pkg::OAG_INH_MASK_SET)
         mask_exp = oag_pkg::MASK_LEVEL_NONE;
      else if (m == 4'h0 && inh == oag_pkg::OAG_INH_MASK_CLEAR)
         mask_exp = oag_pkg::MASK_LEVEL_ALL;
      e.mask = mask_exp;
      exp_q.push_back(e);
      @(posedge clk_i);
      start_i <= 1'b1;
      mode_i <= oag_pkg::oag_mode_e'(m);
      prefix_i <= pfx;
      prefix_valid_i <= pv;
      inh_op_i <= inh;
      rmw_i <= rmw;
      pc_i <= p;
      idx_first_i <= x1;
      idx_second_i <= x2;
      key <= k;
      wt <= w8;
      @(posedge clk_i);
      if (dup) begin
         // a second request while busy must be ignored: an extra done finds no note queued
         @(negedge clk_i);
         `OAG_CHK("busy", 1'b1, busy_o)
         @(posedge clk_i);
      end
      start_i <= 1'b0;
      got = 1'b0;
      for (int n = 0; n < 40 && !got; n++) begin
         @(negedge clk_i);
         got = (done_o === 1'b1);
      end
      if (!got) begin
         miscompares++;
         $display("MISMATCH done expected 1 seen timeout");
         give_verdict();
      end
   endtask

   always @(negedge clk_i) begin
      if (mem_req_o === 1'b1 && mem_valid_i === 1'b1)
         taken = taken + 1;
      if (done_o === 1'b1) begin
         if (exp_q.size() == 0) begin
            miscompares++;
            $display("MISMATCH done expected none seen pulse");
         end else begin
            e_mon = exp_q.pop_front();
            if (e_mon.chk_ea) `OAG_CHK("ea", e_mon.ea, ea_o)
            if (e_mon.chk_npc) `OAG_CHK("next pc", e_mon.npc, next_pc_o)
            if (e_mon.chk_npc) `OAG_CHK("bytes", e_mon.nb, taken)
            if (e_mon.chk_opd) `OAG_CHK("operand", e_mon.opd, operand_o)
            if (e_mon.chk_opd) `OAG_CHK("imm flag", 1'b1, operand_imm_o)
            `OAG_CHK("mask", e_mon.mask, mask_level_o)
            if (e_mon.chk_ill) `OAG_CHK("illegal", 1'b1, illegal_o)
         end
         taken = 0;
      end
   end

   initial begin
      arst_n_i = 1'b0;
      start_i = 1'b0;
      prefix_i = 8'h00;
      prefix_valid_i = 1'b0;
      mode_i = oag_pkg::OAG_INHERENT;
      inh_op_i = oag_pkg::OAG_INH_OTHER;
      rmw_i = 1'b0;
      pc_i = 16'h0000;
      idx_first_i = 8'h00;
      idx_second_i = 8'h00;
      key = 8'h00;
      wt = 2'h0;
      mask_exp = oag_pkg::MASK_LEVEL_NONE;
      repeat (20) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(negedge clk_i);
      `OAG_CHK("reset mask", oag_pkg::MASK_LEVEL_NONE, mask_level_o)
      `OAG_CHK("reset busy", 1'b0, busy_o)
      $display("test reset done");
      for (r = 0; r < 3; r++)
         for (i = 0; i < 21; i++) begin
            rnd_a = $random(seed);
            rnd_b = $random(seed);
            run(tm[i], tp[i], i != 20 && tp[i] != 8'h00, oag_pkg::OAG_INH_OTHER, 1'b0, 1'b0, rnd_a[15:0],
                rnd_a[23:16], rnd_a[31:24], rnd_b[7:0], rnd_b[9:8]);
         end
      $display("test mode table done");
      // key zero puts ff at 00ff, so offsets and pointers hit the top of page zero
      for (i = 0; i < 5; i++)
         run(i == 1 ? 4'h2 : i == 2 ? 4'h3 : 4'h5, i == 0 ? 8'h00 : i == 4 ? 8'h91 : 8'h92, i != 0,
             oag_pkg::OAG_INH_OTHER, 1'b0, 1'b0, 16'h00fe, 8'hff, 8'hff, 8'h00, 2'h1);
      $display("test page zero edge done");
      run(4'h0, 8'h00, 1'b0, oag_pkg::OAG_INH_MASK_CLEAR, 1'b0, 1'b0, 16'h1234, 8'h01, 8'h02, 8'h11, 2'h0);
      run(4'h0, 8'h00, 1'b0, oag_pkg::OAG_INH_OTHER, 1'b0, 1'b0, 16'h1235, 8'h01, 8'h02, 8'h11, 2'h2);
      run(4'h0, 8'h00, 1'b0, oag_pkg::OAG_INH_MASK_SET, 1'b0, 1'b0, 16'h1236, 8'h01, 8'h02, 8'h11, 2'h0);
      $display("test mask ops done");
      for (i = 0; i < 4; i++) begin
         rnd_a = $random(seed);
         run(i == 0 ? 4'h2 : i == 1 ? 4'h5 : i == 2 ? 4'h3 : 4'h6, 8'h00, 1'b0, oag_pkg::OAG_INH_OTHER, 1'b1,
             1'b0, rnd_a[15:0], rnd_a[23:16], 8'h00, rnd_a[31:24], 2'h0);
      end
      $display("test read modify write done");
      rnd_a = $random(seed);
      run(4'h3, 8'h00, 1'b0, oag_pkg::OAG_INH_OTHER, 1'b0, 1'b1, rnd_a[15:0], 8'h00, 8'h00, rnd_a[23:16], 2'h2);
      repeat (4) @(negedge clk_i);
      `OAG_CHK("pending", 0, exp_q.size())
      $display("test busy refusal done");
      give_verdict();
   end
endmodule
`default_nettype wire
